/* File: logic/ppfs_pkg.sv */
// shared constants for the port pin function select block
package ppfs_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADDR_DATA   = 8'h00;
    localparam logic [7:0] ADDR_DIR    = 8'h04;
    localparam logic [7:0] ADDR_PULL   = 8'h08;
    localparam logic [7:0] ADDR_WAKE   = 8'h0c;
    localparam logic [7:0] ADDR_FCTRL  = 8'h10;
    localparam logic [7:0] ADDR_ANA    = 8'h14;
    localparam logic [7:0] ADDR_CFG    = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;

    // ==========================================================
    // reset values
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] PULL_RST = 8'h00;
    localparam logic [7:0] WAKE_RST = 8'h00;

    // ==========================================================
    // field positions
    localparam int FCTRL_PWM_BIT   = 0;
    localparam int ANA_PIN3_BIT    = 3;
    localparam int CFG_OSC_LSB     = 0;
    localparam int CFG_RST_BIT     = 2;
    localparam int STS_WAKE_BIT    = 8;
    localparam int STS_FREQ_LSB    = 9;
    localparam int STS_TWO_TMR_BIT = 11;

    // ==========================================================
    // pin roles
    localparam int PIN_INT     = 3;
    localparam int PIN_PWM     = 4;
    localparam int PIN_OSC_OUT = 5;
    localparam int PIN_OSC_IN  = 6;
    localparam int PIN_RST     = 7;

    localparam logic [7:0] WAKE_ABLE = 8'h7f;
    localparam logic [7:0] PULL_ABLE = 8'h7f;

    // ==========================================================
    // oscillator modes, gray ordered
    typedef enum logic [1:0] {
        OSC_INT_RC = 2'h0,
        OSC_XTAL   = 2'h1,
        OSC_RC_RTC = 2'h3,
        OSC_EXT_RC = 2'h2
    } ppfs_osc_type;

    // internal rc frequency codes
    localparam logic [1:0] RC_4MHZ  = 2'h0;
    localparam logic [1:0] RC_8MHZ  = 2'h1;
    localparam logic [1:0] RC_12MHZ = 2'h2;

endpackage

/* File: logic/ppfs_osc_decode.sv */
// oscillator mode decode for the two oscillator capable pins
`timescale 1ns/1ps
`default_nettype none
module ppfs_osc_decode
    import ppfs_pkg::*;
(
    input  wire ppfs_osc_type mode,
    output logic              osc_in_pin,
    output logic              osc_out_pin
);

    // ==========================================================
    // pin ownership per mode
    always_comb begin
        case (mode)
            OSC_INT_RC: begin
                osc_in_pin  = 1'b0;
                osc_out_pin = 1'b0;
            end
            OSC_XTAL, OSC_RC_RTC: begin
                osc_in_pin  = 1'b1;
                osc_out_pin = 1'b1;
            end
            OSC_EXT_RC: begin
                osc_in_pin  = 1'b1;
                osc_out_pin = 1'b0;
            end
            default: begin
                osc_in_pin  = 1'b0;
                osc_out_pin = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: logic/ppfs_pin_cell.sv */
// one port pin: output, enable and pull-high selection
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_cell
    import ppfs_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic sw_out,
    input  wire logic sw_dir_in,
    input  wire logic pull_req,
    input  wire logic alt_en,
    input  wire logic alt_out,
    input  wire logic io_dis,
    output logic      pad_out,
    output logic      pad_oe,
    output logic      pull_en
);

    // ==========================================================
    // registered pin drive
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
            pull_en <= 1'b0;
        end else begin
            pad_out <= alt_en ? alt_out : sw_out;
            pad_oe  <= !io_dis && (alt_en || !sw_dir_in);
            pull_en <= !io_dis && pull_req;
        end
    end

endmodule
`default_nettype wire

/* File: logic/ppfs_top.sv */
// port pin function select with apb register access
// Notes on behaviour
// - analog select drops pin three io, interrupt, pull
// - control bit routes pwm onto pin four
// - two-timer variant adds timer input on four
// - of four oscillator modes, three own pin six, two own pin five
// - internal rc frequency fixed per device
// - pin seven is reset or plain input
// - pins zero to six may wake device
// - pins zero to six take pull-high
// - software picks output or input per pin
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ppfs_top
    import ppfs_pkg::*;
#(
    parameter bit         TWO_TIMERS   = 1'b1,
    parameter logic [1:0] RC_FREQ_CODE = RC_4MHZ
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  pad_in,
    output logic [7:0]       pad_out,
    output logic [7:0]       pad_oe,
    output logic [7:0]       pull_en,
    input  wire logic        pwm_in,
    output logic             ext_int_r,
    output logic             analog_sel_r,
    output logic             second_timer_event_r,
    output logic             osc_in_en_r,
    output logic             osc_out_en_r,
    output logic [1:0]       rc_freq_r,
    output logic             ext_rst_req_r,
    output logic             wake_up_r
);

    // ==========================================================
    // registers
    logic [7:0]   data_r;
    logic [7:0]   dir_r;
    logic [7:0]   pull_r;
    logic [7:0]   wake_en_r;
    logic         pwm_sel_r;
    ppfs_osc_type osc_mode_r;
    logic         rst_sel_r;
    logic [7:0]   pin_prev_r;
    logic         osc_in_pin;
    logic         osc_out_pin;
    logic [7:0]   io_dis;
    logic [7:0]   alt_en;
    logic [7:0]   alt_out;
    logic         wake_evt;
    logic         acc;
    logic         wr_ok;
    logic [31:0]  rd_nxt;
    logic         hit;

    assign acc   = psel && penable;
    assign wr_ok = acc && pready && pwrite;

    // ==========================================================
    // apb answer, one wait state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            prdata  <= (acc && !pready && !pwrite) ? rd_nxt : 32'h0000_0000;
            pslverr <= acc && !pready && !hit;
        end
    end

    always_comb begin
        hit    = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr)
            ADDR_DATA:  rd_nxt[7:0] = data_r;
            ADDR_DIR:   rd_nxt[7:0] = dir_r;
            ADDR_PULL:  rd_nxt[7:0] = pull_r;
            ADDR_WAKE:  rd_nxt[7:0] = wake_en_r;
            ADDR_FCTRL: rd_nxt[FCTRL_PWM_BIT] = pwm_sel_r;
            ADDR_ANA:   rd_nxt[ANA_PIN3_BIT] = analog_sel_r;
            ADDR_CFG: begin
                rd_nxt[CFG_OSC_LSB +: 2] = osc_mode_r;
                rd_nxt[CFG_RST_BIT]      = rst_sel_r;
            end
            ADDR_STATUS: begin
                rd_nxt[7:0]               = pin_prev_r & ~io_dis;
                rd_nxt[PIN_RST]           = pin_prev_r[PIN_RST] && !rst_sel_r;
                rd_nxt[STS_WAKE_BIT]      = wake_up_r;
                rd_nxt[STS_FREQ_LSB +: 2] = rc_freq_r;
                rd_nxt[STS_TWO_TMR_BIT]   = TWO_TIMERS;
            end
            default:    hit = 1'b0;
        endcase
    end

    // ==========================================================
    // software registers
    // reset defaults inputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_r       <= DATA_RST;
            dir_r        <= DIR_RST;
            pull_r       <= PULL_RST;
            wake_en_r    <= WAKE_RST;
            pwm_sel_r    <= 1'b0;
            analog_sel_r <= 1'b0;
            osc_mode_r   <= OSC_INT_RC;
            rst_sel_r    <= 1'b0;
        end else if (wr_ok) begin
            case (paddr)
                ADDR_DATA:  data_r <= pwdata[7:0];
                ADDR_DIR:   dir_r <= pwdata[7:0];
                ADDR_PULL:  pull_r <= pwdata[7:0] & PULL_ABLE;
                ADDR_WAKE:  wake_en_r <= pwdata[7:0] & WAKE_ABLE;
                ADDR_FCTRL: pwm_sel_r <= pwdata[FCTRL_PWM_BIT];
                ADDR_ANA:   analog_sel_r <= pwdata[ANA_PIN3_BIT];
                ADDR_CFG: begin
                    osc_mode_r <= ppfs_osc_type'(pwdata[CFG_OSC_LSB +: 2]);
                    rst_sel_r  <= pwdata[CFG_RST_BIT];
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // oscillator pin ownership
    // mode decode
    ppfs_osc_decode u_osc (
        .mode        (osc_mode_r),
        .osc_in_pin  (osc_in_pin),
        .osc_out_pin (osc_out_pin)
    );

    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_in_en_r  <= 1'b0;
            osc_out_en_r <= 1'b0;
            rc_freq_r    <= RC_FREQ_CODE;
        end else begin
            osc_in_en_r  <= osc_in_pin;
            osc_out_en_r <= osc_out_pin;
            rc_freq_r    <= RC_FREQ_CODE;
        end
    end

    // ==========================================================
    // per pin function routing
    always_comb begin
        io_dis  = 8'h00;
        alt_en  = 8'h00;
        alt_out = 8'h00;
        io_dis[PIN_INT]     = analog_sel_r;
        io_dis[PIN_OSC_OUT] = osc_out_pin;
        io_dis[PIN_OSC_IN]  = osc_in_pin;
        io_dis[PIN_RST]     = 1'b1;
        alt_en[PIN_PWM]     = pwm_sel_r;
        alt_out[PIN_PWM]    = pwm_in;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            ppfs_pin_cell u_cell (
                .clk       (clk),
                .nrst      (nrst),
                .sw_out    (data_r[gi]),
                .sw_dir_in (dir_r[gi]),
                .pull_req  (pull_r[gi]),
                .alt_en    (alt_en[gi]),
                .alt_out   (alt_out[gi]),
                .io_dis    (io_dis[gi]),
                .pad_out   (pad_out[gi]),
                .pad_oe    (pad_oe[gi]),
                .pull_en   (pull_en[gi])
            );
        end
    endgenerate

    // ==========================================================
    // shared inputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ext_int_r            <= 1'b0;
            second_timer_event_r <= 1'b0;
            ext_rst_req_r        <= 1'b0;
        end else begin
            ext_int_r            <= pad_in[PIN_INT] && !analog_sel_r;
            second_timer_event_r <= TWO_TIMERS && !pwm_sel_r && pad_in[PIN_PWM];
            ext_rst_req_r        <= rst_sel_r && !pad_in[PIN_RST];
        end
    end

    // ==========================================================
    // wake-up detect, set wins over clear
    assign wake_evt = |((pad_in ^ pin_prev_r) & wake_en_r & ~io_dis);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_prev_r <= 8'h00;
            wake_up_r  <= 1'b0;
        end else begin
            pin_prev_r <= pad_in;
            if (wake_evt) begin
                wake_up_r <= 1'b1;
            end else if (wr_ok && paddr == ADDR_STATUS && pwdata[STS_WAKE_BIT]) begin
                wake_up_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence

    apb_answer_a: assert property (apb_setup_s ##1 apb_wait_s |=> pready)
        else $error("apb answer late");

    ana_pin_off_a: assert property (analog_sel_r |=>
        !pad_oe[PIN_INT] && !pull_en[PIN_INT] && !ext_int_r)
        else $error("analog pin still active");

    pwm_route_a: assert property (pwm_sel_r |=>
        pad_oe[PIN_PWM] && pad_out[PIN_PWM] == $past(pwm_in))
        else $error("pwm not on pin");

    tmr_route_a: assert property (1'b1 |=>
        second_timer_event_r == (TWO_TIMERS && !$past(pwm_sel_r) && $past(pad_in[PIN_PWM])))
        else $error("timer input wrong");

    xtal_pins_a: assert property (osc_mode_r == OSC_XTAL |=>
        osc_in_en_r && osc_out_en_r && pad_oe[6:5] == 2'h0)
        else $error("crystal pins wrong");

    ext_rc_a: assert property (osc_mode_r == OSC_EXT_RC |=>
        osc_in_en_r && !osc_out_en_r)
        else $error("external rc pins wrong");

    rc_freq_a: assert property ($past(nrst) |-> rc_freq_r == RC_FREQ_CODE)
        else $error("rc frequency moved");

    rst_pin_a: assert property (rst_sel_r && !pad_in[PIN_RST] |=> ext_rst_req_r)
        else $error("reset pin ignored");

    wake_set_a: assert property (wake_evt |=> wake_up_r)
        else $error("wake flag lost");

    pin7_pull_a: assert property (!pull_en[PIN_RST] && !pad_oe[PIN_RST])
        else $error("pin seven driven or pulled");

    dir_out_a: assert property (!dir_r[0] |=>
        pad_oe[0] && pad_out[0] == $past(data_r[0]))
        else $error("output pin not driven");

    reset_dflt_a: assert property (disable iff (1'b0) !nrst |=>
        pad_oe == 8'h00 && !wake_up_r && !pwm_sel_r && !analog_sel_r)
        else $error("reset defaults wrong");

    int_rc_a: assert property (osc_mode_r == OSC_INT_RC |=>
        !osc_in_en_r && !osc_out_en_r)
        else $error("internal rc pins wrong");

    rtc_pins_a: assert property (osc_mode_r == OSC_RC_RTC |=>
        osc_in_en_r && osc_out_en_r)
        else $error("rtc pins wrong");

    wake_hold_a: assert property (wake_up_r && !wr_ok |=> wake_up_r)
        else $error("wake flag dropped");

    apb_err_a: assert property (pslverr |-> pready)
        else $error("error without ready");

endmodule
`default_nettype wire

/* File: dv/ppfs_pin_model.sv */
// external circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module ppfs_pin_model (
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pull_en,
    input  wire logic [7:0] ext_drv,
    input  wire logic [7:0] ext_en,
    output logic [7:0]      pad_in
);
    // ==========================================================
    // wire level
    logic [7:0] float_r = 8'h00;
    // an undriven, unpulled line keeps changing
    always @(posedge clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_drv[i];
            else if (pull_en[i]) pad_in[i] = 1'b1;
            else pad_in[i] = float_r[i];
        end
    end
endmodule
`default_nettype wire

/* File: dv/test_port_pin_function_select.sv */
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_select;
    import ppfs_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pwm_in = 0;
    logic [7:0] paddr = 8'h00, ext_drv = 8'h00, ext_en = 8'hff, pad_in;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ext_int_r, analog_sel_r, second_timer_event_r;
    logic osc_in_en_r, osc_out_en_r, ext_rst_req_r, wake_up_r;
    logic [7:0] pad_out, pad_oe, pull_en;
    logic [1:0] rc_freq_r;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    ppfs_top i_ppfs_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_en(pull_en), .pwm_in(pwm_in), .ext_int_r(ext_int_r),
        .analog_sel_r(analog_sel_r), .second_timer_event_r(second_timer_event_r),
        .osc_in_en_r(osc_in_en_r), .osc_out_en_r(osc_out_en_r), .rc_freq_r(rc_freq_r),
        .ext_rst_req_r(ext_rst_req_r), .wake_up_r(wake_up_r));
    ppfs_pin_model i_ppfs_pin_model (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_en(pull_en), .ext_drv(ext_drv), .ext_en(ext_en), .pad_in(pad_in));
    initial forever #2.5 clk = ~clk;
    // ==========================================================
    // timeout and verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic final_report();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // apb master
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        cmp(rd, exp);
        cmp(err, 1'b0);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        cmp(pad_oe, 8'h00);
        cmp(pull_en, 8'h00);
        cmp(analog_sel_r, 1'b0);
        cmp(rc_freq_r, RC_4MHZ);
        rdc(ADDR_DIR, 32'hff);
        rdc(ADDR_STATUS, 32'h800);
    endtask
    task automatic t_dir();
        wr(ADDR_DIR, 32'h0);
        wr(ADDR_DATA, 32'h5a);
        settle();
        cmp(pad_oe, 8'h7f);
        cmp(pad_out[6:0], 7'h5a);
        wr(ADDR_DIR, 32'hff);
        settle();
        cmp(pad_oe, 8'h00);
    endtask
    task automatic t_pull();
        wr(ADDR_PULL, 32'hff);
        rdc(ADDR_PULL, 32'h7f);
        settle();
        cmp(pull_en, 8'h7f);
        ext_en[1] <= 1'b0;
        settle();
        rdc(ADDR_STATUS, 32'h802);
        ext_en[1] <= 1'b1;
    endtask
    task automatic t_analog();
        ext_drv[3] <= 1'b1;
        settle();
        cmp(ext_int_r, 1'b1);
        wr(ADDR_ANA, 32'h8);
        wr(ADDR_DIR, 32'h0);
        settle();
        cmp(analog_sel_r, 1'b1);
        cmp(pull_en, 8'h77);
        cmp(pad_oe, 8'h77);
        cmp(ext_int_r, 1'b0);
        wr(ADDR_ANA, 32'h0);
        wr(ADDR_DIR, 32'hff);
        wr(ADDR_PULL, 32'h0);
        ext_drv <= 8'h00;
    endtask
    task automatic t_pwm();
        ext_drv[4] <= 1'b1;
        settle();
        cmp(second_timer_event_r, 1'b1);
        wr(ADDR_FCTRL, 32'h1);
        wr(ADDR_DIR, 32'h0);
        pwm_in <= 1'b1;
        settle();
        cmp(pad_out[4], 1'b1);
        pwm_in <= 1'b0;
        settle();
        cmp(pad_out[4], 1'b0);
        cmp(second_timer_event_r, 1'b0);
        wr(ADDR_FCTRL, 32'h0);
        wr(ADDR_DIR, 32'hff);
        ext_drv <= 8'h00;
    endtask
    task automatic t_osc();
        ppfs_osc_type m [4] = '{OSC_INT_RC, OSC_XTAL, OSC_RC_RTC, OSC_EXT_RC};
        logic [3:0] e_in = 4'b1110, e_out = 4'b0110;
        wr(ADDR_DIR, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CFG, {30'h0, m[i]});
            settle();
            cmp(osc_in_en_r, e_in[i]);
            cmp(osc_out_en_r, e_out[i]);
            cmp(pad_oe[6:5], {~e_in[i], ~e_out[i]});
        end
        wr(ADDR_CFG, 32'h0);
        wr(ADDR_DIR, 32'hff);
    endtask
    task automatic t_rst_pin();
        wr(ADDR_CFG, 32'h4);
        settle();
        cmp(ext_rst_req_r, 1'b1);
        ext_drv[7] <= 1'b1;
        settle();
        cmp(ext_rst_req_r, 1'b0);
        ext_drv[7] <= 1'b0;
        wr(ADDR_CFG, 32'h0);
        settle();
        cmp(ext_rst_req_r, 1'b0);
    endtask
    task automatic t_wake();
        wr(ADDR_WAKE, 32'hff);
        rdc(ADDR_WAKE, 32'h7f);
        cmp(wake_up_r, 1'b0);
        ext_drv[0] <= 1'b1;
        settle();
        cmp(wake_up_r, 1'b1);
        rdc(ADDR_STATUS, 32'h901);
        wr(ADDR_STATUS, 32'h100);
        settle();
        cmp(wake_up_r, 1'b0);
        ext_drv[7] <= 1'b1;
        settle();
        cmp(wake_up_r, 1'b0);
        rdc(ADDR_STATUS, 32'h881);
        wr(ADDR_WAKE, 32'h0);
        ext_drv <= 8'h00;
    endtask
    task automatic t_unmapped();
        logic [31:0] rd;
        logic err;
        apb(1'b0, 8'h20, 32'h0, rd, err);
        cmp(err, 1'b1);
        cmp(rd, 32'h0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_dir();
        t_pull();
        t_analog();
        t_pwm();
        t_osc();
        t_rst_pin();
        t_wake();
        t_unmapped();
        final_report();
    end
endmodule
`default_nettype wire
